// >>> include/dfc_pkg.sv
// Purpose: Constants for the DMA flag clear and status block, channels 2 to 5
// Assumes: 32-bit register port, byte offsets
// Notes: Each channel owns four bits, ordered any, done, halfway, fault
package dfc_pkg;
  localparam int unsigned FIRST_CH = 2;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned BITS_PER_CH = 4;
  // Field positions within a channel nibble
  localparam int unsigned FLD_ANY = 0;
  localparam int unsigned FLD_DONE = 1;
  localparam int unsigned FLD_HALF = 2;
  localparam int unsigned FLD_FAULT = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG_STATUS = 8'h00;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  // Reset values
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage

// >>> design/dfc_top.sv
// Purpose: Per-channel event flags of DMA channels 2 to 5 with write-one-to-clear
// Assumes: Event inputs are one-cycle pulses from the transfer logic on clk
// Notes: Flag status and clear registers use the shared 4-bits-per-channel map
// Function
// - Global clear bit clears all four flags
// - Done clear bit clears only done flag
// - Halfway clear bit clears only halfway flag
// - Fault clear bit clears only fault flag
// - Channel 2 clears at bits 8 to 11
// - Channel 3 clears at bits 12 to 15
// - Channel 4 clears at bits 16 to 19
// - Channel 5 clears at bits 20 to 23
// - Events set flags; any-flag follows; sticky
`timescale 1ns/1ps
`default_nettype none
module dfc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [3:0] done_evt,
  input wire logic [3:0] half_evt,
  input wire logic [3:0] fault_evt,
  output logic [15:0] flag_status,
  output logic irq
);

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
  } dfc_state_type;

  dfc_state_type st_r;
  dfc_state_type st_nxt;

  // Bit index of a field of local channel ch in the 32-bit register map
  function automatic int unsigned map_bit(input int unsigned ch, input int unsigned fld);
    map_bit = (dfc_pkg::FIRST_CH + ch) * dfc_pkg::BITS_PER_CH + fld;
  endfunction

  // Bit index of a field of local channel ch in the 16-bit internal vectors
  function automatic int unsigned loc_bit(input int unsigned ch, input int unsigned fld);
    loc_bit = ch * dfc_pkg::BITS_PER_CH + fld;
  endfunction

  always_comb begin
    logic clr_wr;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [31:0] flags_word;
    logic [31:0] irq_word;
    logic [31:0] mask_word;
    st_nxt = st_r;
    set_v = 16'h0000;
    clr_v = 16'h0000;
    flags_word = 32'h0000_0000;
    irq_word = 32'h0000_0000;
    mask_word = 32'h0000_0000;
    clr_wr = wr_stb && (addr == dfc_pkg::OFS_FLAG_CLEAR);
    for (int unsigned c = 0; c < dfc_pkg::NUM_CH; c++) begin
      // Hardware events; any-flag rides along with each
      set_v[loc_bit(c, dfc_pkg::FLD_DONE)] = done_evt[c];
      set_v[loc_bit(c, dfc_pkg::FLD_HALF)] = half_evt[c];
      set_v[loc_bit(c, dfc_pkg::FLD_FAULT)] = fault_evt[c];
      set_v[loc_bit(c, dfc_pkg::FLD_ANY)] = done_evt[c] | half_evt[c] | fault_evt[c];
      if (clr_wr) begin
        // Decode positions follow the channel number: ch2 at 8..11 up to ch5 at 20..23
        clr_v[loc_bit(c, dfc_pkg::FLD_DONE)] = wdata[map_bit(c, dfc_pkg::FLD_DONE)];
        clr_v[loc_bit(c, dfc_pkg::FLD_HALF)] = wdata[map_bit(c, dfc_pkg::FLD_HALF)];
        clr_v[loc_bit(c, dfc_pkg::FLD_FAULT)] = wdata[map_bit(c, dfc_pkg::FLD_FAULT)];
        if (wdata[map_bit(c, dfc_pkg::FLD_ANY)]) begin
          clr_v[loc_bit(c, dfc_pkg::FLD_ANY) +: dfc_pkg::BITS_PER_CH] = 4'hf;
        end
      end
      flags_word[map_bit(c, 0) +: dfc_pkg::BITS_PER_CH] =
        st_r.flags[loc_bit(c, 0) +: dfc_pkg::BITS_PER_CH];
      irq_word[map_bit(c, 0) +: dfc_pkg::BITS_PER_CH] =
        st_r.irq_stat[loc_bit(c, 0) +: dfc_pkg::BITS_PER_CH];
      mask_word[map_bit(c, 0) +: dfc_pkg::BITS_PER_CH] =
        st_r.irq_mask[loc_bit(c, 0) +: dfc_pkg::BITS_PER_CH];
    end
    // Zeros in the clear word leave flags alone; a same-cycle event wins
    st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
    // Sticky interrupt status, cleared by reading it, event wins
    if (rd_stb && (addr == dfc_pkg::OFS_IRQ_STATUS)) begin
      st_nxt.irq_stat = set_v;
    end else begin
      st_nxt.irq_stat = st_r.irq_stat | set_v;
    end
    if (wr_stb && (addr == dfc_pkg::OFS_IRQ_MASK)) begin
      for (int unsigned c = 0; c < dfc_pkg::NUM_CH; c++) begin
        st_nxt.irq_mask[loc_bit(c, 0) +: dfc_pkg::BITS_PER_CH] =
          wdata[map_bit(c, 0) +: dfc_pkg::BITS_PER_CH];
      end
    end
    // Read data valid only in the cycle after the strobe; clear register reads zero
    st_nxt.rdata = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        dfc_pkg::OFS_FLAG_STATUS: st_nxt.rdata = flags_word;
        dfc_pkg::OFS_IRQ_STATUS: st_nxt.rdata = irq_word;
        dfc_pkg::OFS_IRQ_MASK: st_nxt.rdata = mask_word;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.flags <= dfc_pkg::RST_FLAGS;
      st_r.irq_stat <= dfc_pkg::RST_FLAGS;
      st_r.irq_mask <= dfc_pkg::RST_IRQ_MASK;
      st_r.rdata <= dfc_pkg::RST_RDATA;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign flag_status = st_r.flags;
  assign irq = st_r.irq;

endmodule
`default_nettype wire

// >>> sim/dfc_asserts.sv
// Purpose: Checker on dfc_top ports
// Assumes: Clear register at 0x04
// Notes: Bound to every dfc_top
`timescale 1ns/1ps
`default_nettype none
module dfc_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [3:0] done_evt,
  input wire logic [3:0] half_evt,
  input wire logic [3:0] fault_evt,
  input wire logic [15:0] flag_status,
  input wire logic irq
);
  wire w = wr_stb && addr == 8'h04;
  wire [3:0] e = done_evt | half_evt | fault_evt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_all; w && wdata[12] && !e[1] |=> flag_status[7:4] == 4'h0; endproperty
  a_all: assert property (p_all) else $error("clear all");
  property p_done; w && wdata[9] && !done_evt[0] |=> !flag_status[1]; endproperty
  a_done: assert property (p_done) else $error("clear done");
  property p_half; w && wdata[18] && !half_evt[2] |=> !flag_status[10]; endproperty
  a_half: assert property (p_half) else $error("clear half");
  property p_fault; w && wdata[15] && !fault_evt[1] |=> !flag_status[7]; endproperty
  a_fault: assert property (p_fault) else $error("clear fault");
  property p_ch5; w && wdata[22:20] == 3'h6 && !e[3]
    |=> flag_status[14:13] == 2'h0 && flag_status[12] == $past(flag_status[12]); endproperty
  a_ch5: assert property (p_ch5) else $error("chan5 clear");
  property p_keep; (!w || wdata[11:8] == 4'h0) && !e[0] |=> $stable(flag_status[3:0]); endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_set; e[2] |=> flag_status[8]; endproperty
  a_set: assert property (p_set) else $error("any not set");
  property p_hset; half_evt[0] |=> flag_status[2] && flag_status[0]; endproperty
  a_hset: assert property (p_hset) else $error("half not set");
endmodule
bind dfc_top dfc_asserts u_chk (.*);
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Random bench for dfc_top
// Assumes: Model tracks flags, irq and reads
// Notes: Values are checked at each edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, irq, q = 0, wr, rd;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r = 0, w;
  logic [3:0] done_evt = 0, half_evt = 0, fault_evt = 0;
  logic [15:0] flag_status, m = 0, s = 0, k = 0, ev;
  int n_fail = 0, tests_run = 0, cyc = 0;
  dfc_top dut (.*);
  function automatic logic [15:0] nx(logic [15:0] f, logic [31:0] c, logic [15:0] e);
    logic [15:0] cl;
    cl = c[23:8] & 16'heeee;
    for (int i = 0; i < 4; i++) if (c[8+4*i]) cl[4*i+:4] = 4'hf;
    return (f & ~cl) | e;
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(4597));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 2000; n++) begin
      @(posedge clk);
      `CHK(flag_status, m)
      `CHK(irq, q)
      `CHK(rdata, r)
      for (int i = 0; i < 4; i++)
        ev[4*i+:4] = {fault_evt[i], half_evt[i], done_evt[i], |{fault_evt[i], half_evt[i], done_evt[i]}};
      w = wr_stb && addr == 8'h04 ? wdata : 32'h0;
      r = !rd_stb ? 32'h0 : addr == 8'h00 ? {8'h00, m, 8'h00} : addr == 8'h08 ? {8'h00, s, 8'h00}
        : addr == 8'h0c ? {8'h00, k, 8'h00} : 32'h0;
      if (rd_stb && addr == 8'h08) s = 16'h0;
      s |= ev;
      if (wr_stb && addr == 8'h0c) k = wdata[23:8];
      m = nx(m, w, ev);
      q = |(s & k);
      wr = $urandom % 3 == 0;
      rd = !wr && $urandom % 3 == 0;
      wr_stb <= wr;
      rd_stb <= rd;
      addr <= 8'(32'h0000_0004 * ($urandom % 5));
      wdata <= n % 64 == 0 ? 32'hffff_ffff : n % 64 == 1 ? 32'h0 : $urandom;
      done_evt <= 4'($urandom & $urandom);
      half_evt <= 4'($urandom & $urandom);
      fault_evt <= 4'($urandom & $urandom & $urandom);
    end
    stop_test();
  end
endmodule
`default_nettype wire
